//--- design/tio_pkg.sv
// Shared constants and carriers for the tester control and judgment I/O block.
// Assumes a single 50 MHz system clock and an APB master on the register side.
package tio_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CMD = 4'hC;

  // Control register fields
  localparam int CTL_CMP = 0;
  localparam int CTL_RRJ = 1;
  localparam int CTL_RRM = 2;
  localparam int CTL_LOCK = 3;
  localparam int CTL_W = 4;
  localparam logic [CTL_W-1:0] CTRL_RST = 4'h7;

  // Result register fields
  localparam int RES_V_LSB = 0;
  localparam int RES_R_LSB = 2;
  localparam int RES_RR_LSB = 4;
  localparam int RES_ERR = 6;

  // Status register fields
  localparam int ST_START = 0;
  localparam int ST_OHMCAL = 1;
  localparam int ST_VOLTCAL = 2;
  localparam int ST_ZERO = 3;
  localparam int ST_KEYLOCK = 4;
  localparam int ST_PANEL_LSB = 5;
  localparam int ST_BUSY = 8;
  localparam int ST_DONE = 9;
  localparam int EVT_W = 4;

  // Command register fields
  localparam int CMD_START = 0;

  // Judgment codes; route uses 1 pass, 2 warning, 3 fail
  localparam logic [1:0] JDG_NONE = 2'h0;
  localparam logic [1:0] JDG_HI = 2'h1;
  localparam logic [1:0] JDG_IN = 2'h2;
  localparam logic [1:0] JDG_LO = 2'h3;

  typedef struct packed {
    logic ext_start;
    logic ohm_selfcal;
    logic volt_selfcal;
    logic zero_trim;
    logic key_lock;
    logic [2:0] panel_sel;
  } ctrl_pins_s;

  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } tri_s;

  typedef struct packed {
    tri_s volt;
    tri_s ohm;
    tri_s route;
    logic pass1;
    logic fail1;
    logic pass2;
    logic fail2;
    logic err;
  } judge_s;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_MEAS = 2'b01,
    MS_JUDGE = 2'b10,
    MS_DONE = 2'b11
  } meas_e;

endpackage : tio_pkg

//--- design/test_control_io_judgment.sv
// Control inputs and judgment outputs of the battery tester, with an APB register slave.
// Assumes external pins are asynchronous and the measurement engine reports results over APB.
`timescale 1ns/1ps
`default_nettype none
module test_control_io_judgment
  import tio_pkg::*;
#(
  parameter int APB_ADDR_W = 4
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Control pins
  input wire logic ext_start_in,
  input wire logic ohm_selfcal_in,
  input wire logic volt_selfcal_in,
  input wire logic zero_trim_in,
  input wire logic key_lock_in,
  input wire logic panel_sel_b0_in,
  input wire logic panel_sel_b1_in,
  input wire logic panel_sel_b2_in,
  // Requests to the instrument core
  output logic start_req_out,
  output logic ohm_cal_req_out,
  output logic volt_cal_req_out,
  output logic zero_trim_req_out,
  output logic keys_locked_out,
  output logic [2:0] panel_sel_out,
  // Judgment pins
  output logic volt_above_out,
  output logic volt_inside_out,
  output logic volt_below_out,
  output logic ohm_above_out,
  output logic ohm_inside_out,
  output logic ohm_below_out,
  output logic route_pass_out,
  output logic route_warn_out,
  output logic route_fail_out,
  output logic pass1_out,
  output logic fail1_out,
  output logic pass2_out,
  output logic fail2_out,
  output logic meas_err_out,
  output logic measure_done_out,
  output logic index_out
);

  initial
  begin
    if (APB_ADDR_W < 4)
      $error("APB_ADDR_W too small for register map");
  end

  function automatic tri_s dec_code(input logic [1:0] code, input logic en);
    tri_s t;
    t.hi = en && (code == JDG_HI);
    t.mid = en && (code == JDG_IN);
    t.lo = en && (code == JDG_LO);
    return t;
  endfunction : dec_code

  ctrl_pins_s pins_w;
  ctrl_pins_s s1_r, s2_r, s3_r, stable_r, stable_nxt, rise_w;
  logic [CTL_W-1:0] ctrl_r;
  logic [6:0] raw_r;
  logic [EVT_W-1:0] evt_r;
  logic [2:0] panel_r;
  logic keylock_r;
  logic start_w, ohmcal_w, voltcal_w, zero_w, locked_w;
  logic wr_w, setup_w, map_w;
  logic [3:0] addr_w;
  meas_e ms_r;
  judge_s judge_r;
  tri_s v_w, r_w, rr_w;

  assign pins_w = {ext_start_in, ohm_selfcal_in, volt_selfcal_in, zero_trim_in,
                   key_lock_in, panel_sel_b2_in, panel_sel_b1_in, panel_sel_b0_in};
  assign locked_w = ctrl_r[CTL_LOCK];
  assign addr_w = paddr_in[3:0];
  assign setup_w = psel_in && !penable_in;
  assign wr_w = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
  assign map_w = (paddr_in[1:0] == 2'h0) && (paddr_in >> 4 == '0);

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stable_r <= '0;
    end
    else
    begin
      s1_r <= pins_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= stable_nxt;
    end
  end

  assign stable_nxt = (s2_r & ~(s2_r ^ s3_r)) | (stable_r & (s2_r ^ s3_r));
  // Edges dropped while remote lock holds
  assign rise_w = locked_w ? '0 : (stable_nxt & ~stable_r);
  assign start_w = (rise_w.ext_start || (wr_w && addr_w == OFS_CMD && pwdata_in[CMD_START]))
                   && ms_r == MS_IDLE;
  assign ohmcal_w = rise_w.ohm_selfcal;
  assign voltcal_w = rise_w.volt_selfcal;
  assign zero_w = rise_w.zero_trim;

  // Core request pulses, one cycle per accepted edge or accepted start command
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      start_req_out <= 1'b0;
      ohm_cal_req_out <= 1'b0;
      volt_cal_req_out <= 1'b0;
      zero_trim_req_out <= 1'b0;
    end
    else
    begin
      start_req_out <= start_w;
      ohm_cal_req_out <= ohmcal_w;
      volt_cal_req_out <= voltcal_w;
      zero_trim_req_out <= zero_w;
    end
  end

  // Levels freeze at their last value while remote lock holds
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      keylock_r <= 1'b0;
      panel_r <= '0;
    end
    else if (!locked_w)
    begin
      keylock_r <= stable_nxt.key_lock;
      panel_r <= stable_nxt.panel_sel;
    end
  end

  assign keys_locked_out = keylock_r;
  assign panel_sel_out = panel_r;

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      evt_r <= '0;
    else
    begin
      logic [EVT_W-1:0] clr;
      clr = (wr_w && addr_w == OFS_STATUS) ? pwdata_in[EVT_W-1:0] : '0;
      evt_r <= (evt_r & ~clr) | {zero_w, voltcal_w, ohmcal_w, start_w};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      ctrl_r <= CTRL_RST;
    else if (wr_w && addr_w == OFS_CTRL)
      ctrl_r <= pwdata_in[CTL_W-1:0];
  end

  // Measurement sequence: result lands, judgments settle, then done
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ms_r <= MS_IDLE;
      measure_done_out <= 1'b0;
      index_out <= 1'b0;
      raw_r <= '0;
    end
    else
    begin
      case (ms_r)
        MS_IDLE:
        begin
          if (start_w)
          begin
            ms_r <= MS_MEAS;
            measure_done_out <= 1'b0;
            index_out <= 1'b1;
          end
        end
        MS_MEAS:
        begin
          if (wr_w && addr_w == OFS_RESULT)
          begin
            raw_r <= pwdata_in[6:0];
            index_out <= 1'b0;
            ms_r <= MS_JUDGE;
          end
        end
        MS_JUDGE:
          ms_r <= MS_DONE;
        MS_DONE:
        begin
          measure_done_out <= 1'b1;
          ms_r <= MS_IDLE;
        end
        default:
          ms_r <= MS_IDLE;
      endcase
    end
  end

  // Single decode per group gives at most one active line
  assign v_w = dec_code(raw_r[RES_V_LSB +: 2], ctrl_r[CTL_CMP]);
  assign r_w = dec_code(raw_r[RES_R_LSB +: 2], ctrl_r[CTL_CMP]);
  assign rr_w = dec_code(raw_r[RES_RR_LSB +: 2], ctrl_r[CTL_RRM]);

  // Capability gates also apply to a held result when switched off
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      judge_r <= '0;
    else
    begin
      judge_r.volt <= v_w;
      judge_r.ohm <= r_w;
      judge_r.route <= rr_w;
      judge_r.pass1 <= v_w.mid && r_w.mid;
      judge_r.fail1 <= v_w.hi || v_w.lo || r_w.hi || r_w.lo;
      judge_r.pass2 <= ctrl_r[CTL_RRJ] && v_w.mid && r_w.mid && (raw_r[RES_RR_LSB +: 2] == JDG_HI ||
                       raw_r[RES_RR_LSB +: 2] == JDG_IN);
      judge_r.fail2 <= ctrl_r[CTL_RRJ] && ctrl_r[CTL_CMP] && (v_w.hi || v_w.lo || r_w.hi || r_w.lo ||
                       raw_r[RES_RR_LSB +: 2] == JDG_LO);
      judge_r.err <= raw_r[RES_ERR];
    end
  end

  assign {volt_above_out, volt_inside_out, volt_below_out} = judge_r.volt;
  assign {ohm_above_out, ohm_inside_out, ohm_below_out} = judge_r.ohm;
  assign {route_pass_out, route_warn_out, route_fail_out} = judge_r.route;
  assign pass1_out = judge_r.pass1;
  assign fail1_out = judge_r.fail1;
  assign pass2_out = judge_r.pass2;
  assign fail2_out = judge_r.fail2;
  assign meas_err_out = judge_r.err;

  // APB: ready in every access phase, read data caught in setup
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end
    else
    begin
      pready_out <= setup_w;
      pslverr_out <= setup_w && !map_w;
      if (setup_w)
      begin
        prdata_out <= '0;
        case (addr_w)
          OFS_CTRL:
            prdata_out[CTL_W-1:0] <= ctrl_r;
          OFS_RESULT:
            prdata_out[6:0] <= raw_r;
          OFS_STATUS:
          begin
            prdata_out[EVT_W-1:0] <= evt_r;
            prdata_out[ST_KEYLOCK] <= keylock_r;
            prdata_out[ST_PANEL_LSB +: 3] <= panel_r;
            prdata_out[ST_BUSY] <= ms_r != MS_IDLE;
            prdata_out[ST_DONE] <= measure_done_out;
          end
          default:
            prdata_out <= '0;
        endcase
      end
    end
  end

  chk_start_edge: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(stable_r.ext_start) && !$past(locked_w) && $past(ms_r) == MS_IDLE |-> start_req_out)
    else $error("start edge not turned into a request");
  chk_lock_blocks: assert property (@(posedge clk_in) disable iff (srst_in)
    $past(locked_w) |-> !ohm_cal_req_out && !volt_cal_req_out && !zero_trim_req_out)
    else $error("calibration request passed while locked");
  chk_zero_single: assert property (@(posedge clk_in) disable iff (srst_in)
    zero_trim_req_out |=> !zero_trim_req_out)
    else $error("zero trim request longer than one cycle");
  chk_pass1_cause: assert property (@(posedge clk_in) disable iff (srst_in)
    pass1_out |-> volt_inside_out && ohm_inside_out)
    else $error("first pass without both In");
  chk_fail1_cause: assert property (@(posedge clk_in) disable iff (srst_in)
    (volt_above_out || volt_below_out || ohm_above_out || ohm_below_out) |-> fail1_out)
    else $error("first fail missing on Hi or Lo");
  chk_pass2_route: assert property (@(posedge clk_in) disable iff (srst_in)
    pass2_out |-> pass1_out && (route_pass_out || route_warn_out || !$past(ctrl_r[CTL_RRM])))
    else $error("second pass without route pass or warning");
  chk_cmp_off: assert property (@(posedge clk_in) disable iff (srst_in)
    !ctrl_r[CTL_CMP] ##1 !ctrl_r[CTL_CMP] |-> !volt_inside_out && !ohm_above_out && !pass1_out && !fail1_out)
    else $error("comparator outputs active while disabled");
  chk_rrj_off: assert property (@(posedge clk_in) disable iff (srst_in)
    !ctrl_r[CTL_RRJ] |=> !pass2_out && !fail2_out)
    else $error("second overall outputs active while disabled");
  chk_route_onehot: assert property (@(posedge clk_in) disable iff (srst_in)
    $onehot0({route_pass_out, route_warn_out, route_fail_out}) && $onehot0(judge_r.volt) && $onehot0(judge_r.ohm))
    else $error("more than one judgment in a group");
  chk_done_after: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(measure_done_out) |-> $stable(judge_r) && $past(ms_r, 2) == MS_JUDGE)
    else $error("end of measurement before judgments settled");

endmodule : test_control_io_judgment
`default_nettype wire

//--- tb/ctrl_partner.sv
// Model of the automation controller that drives the tester's control pins.
// Assumes the tester samples its pins on rising edges of clk_in.
`timescale 1ns/1ps
`default_nettype none
module ctrl_partner
  import tio_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Pins toward the tester
  output var ctrl_pins_s pins_out
);
  initial pins_out = '0;
  // Held six cycles so the pin filter sees one clean edge; idx 0 start .. 3 zero trim
  task automatic pulse(input int idx);
    @(posedge clk_in);
    pins_out[7-idx] <= 1'b1;
    repeat (6) @(posedge clk_in);
    pins_out[7-idx] <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : pulse
  task automatic level(input logic k, input logic [2:0] p);
    @(posedge clk_in);
    pins_out.key_lock <= k;
    pins_out.panel_sel <= p;
  endtask : level
endmodule : ctrl_partner
`default_nettype wire

//--- tb/test_control_io_judgment_tb_top.sv
// Self-checking bench for the control and judgment I/O block.
// Assumes an APB slave that answers in its own time and a controller model on the pins.
`timescale 1ns/1ps
`default_nettype none
module test_control_io_judgment_tb_top
  import tio_pkg::*;
;
  logic clk_in = 0, srst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [3:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, q;
  logic pready_out, pslverr_out, e, start_req_out, ohm_cal_req_out, volt_cal_req_out, zero_trim_req_out;
  logic keys_locked_out, volt_above_out, volt_inside_out, volt_below_out, ohm_above_out, ohm_inside_out;
  logic ohm_below_out, route_pass_out, route_warn_out, route_fail_out, pass1_out, fail1_out, pass2_out;
  logic fail2_out, meas_err_out, measure_done_out, index_out;
  logic [2:0] panel_sel_out;
  logic [13:0] obs;
  ctrl_pins_s pins;
  int err_count = 0, n_compared = 0, n, cnt[4] = '{0, 0, 0, 0};
  always #10 clk_in = ~clk_in;
  assign obs = {volt_above_out, volt_inside_out, volt_below_out, ohm_above_out, ohm_inside_out, ohm_below_out,
    route_pass_out, route_warn_out, route_fail_out, pass1_out, fail1_out, pass2_out, fail2_out, meas_err_out};
  ctrl_partner partner (.clk_in, .pins_out(pins));
  test_control_io_judgment DUT (.clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .ext_start_in(pins.ext_start), .ohm_selfcal_in(pins.ohm_selfcal),
    .volt_selfcal_in(pins.volt_selfcal), .zero_trim_in(pins.zero_trim), .key_lock_in(pins.key_lock),
    .panel_sel_b0_in(pins.panel_sel[0]), .panel_sel_b1_in(pins.panel_sel[1]), .panel_sel_b2_in(pins.panel_sel[2]),
    .start_req_out, .ohm_cal_req_out, .volt_cal_req_out, .zero_trim_req_out, .keys_locked_out, .panel_sel_out,
    .volt_above_out, .volt_inside_out, .volt_below_out, .ohm_above_out, .ohm_inside_out, .ohm_below_out,
    .route_pass_out, .route_warn_out, .route_fail_out, .pass1_out, .fail1_out, .pass2_out, .fail2_out,
    .meas_err_out, .measure_done_out, .index_out);
  // Request pulses counted so a doubled or missing pulse shows
  always @(posedge clk_in)
  begin
    cnt[0] += (start_req_out === 1'b1);
    cnt[1] += (ohm_cal_req_out === 1'b1);
    cnt[2] += (volt_cal_req_out === 1'b1);
    cnt[3] += (zero_trim_req_out === 1'b1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // Read data is taken at the edge where pready is sampled high
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  function automatic logic [2:0] tri3(input logic [1:0] k);
    return (k == 2'h1) ? 3'b100 : (k == 2'h2) ? 3'b010 : (k == 2'h3) ? 3'b001 : 3'b000;
  endfunction : tri3
  function automatic logic [13:0] jexp(input logic [3:0] c, input logic [1:0] v, r, t, input logic er);
    logic vi, ri, vf, rf;
    vi = (v == 2'h2);
    ri = (r == 2'h2);
    vf = (v == 2'h1 || v == 2'h3);
    rf = (r == 2'h1 || r == 2'h3);
    return {c[0] ? tri3(v) : 3'b000, c[0] ? tri3(r) : 3'b000, c[2] ? tri3(t) : 3'b000, c[0] & vi & ri,
      c[0] & (vf | rf), c[0] & c[1] & vi & ri & (t == 2'h1 || t == 2'h2), c[0] & c[1] & (vf | rf | t == 2'h3), er};
  endfunction : jexp
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(obs, 14'h0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0007);
    apb(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    for (int v = 1; v < 4; v++)
      for (int r = 1; r < 4; r++)
        for (int t = 1; t < 4; t++)
        begin
          partner.pulse(0);
          for (n = 0; n < 40 && index_out !== 1'b1; n++) @(posedge clk_in);
          chk({index_out, measure_done_out}, 2'b10);
          apb(1'b1, OFS_RESULT, {25'h0, 1'(v == r), 2'(t), 2'(r), 2'(v)});
          for (n = 0; n < 40 && measure_done_out !== 1'b1; n++) @(posedge clk_in);
          chk({index_out, obs}, jexp(4'h7, 2'(v), 2'(r), 2'(t), v == r));
          repeat (3) @(posedge clk_in);
          chk({measure_done_out, obs}, {1'b1, jexp(4'h7, 2'(v), 2'(r), 2'(t), v == r)});
          for (int c = 0; c < 7; c++)
          begin
            apb(1'b1, OFS_CTRL, 32'(c));
            repeat (2) @(posedge clk_in);
            chk(obs[13:1], jexp(4'(c), 2'(v), 2'(r), 2'(t), 1'b0) >> 1);
          end
          apb(1'b1, OFS_CTRL, 32'h0000_0007);
        end
    chk(cnt[0], 27);
    for (int i = 1; i < 4; i++) partner.pulse(i);
    repeat (6) @(posedge clk_in);
    chk(cnt[1], 1);
    chk(cnt[2], 1);
    chk(cnt[3], 1);
    partner.level(1'b1, 3'h5);
    repeat (8) @(posedge clk_in);
    chk({keys_locked_out, panel_sel_out}, 4'hD);
    partner.level(1'b0, 3'h2);
    repeat (8) @(posedge clk_in);
    chk({keys_locked_out, panel_sel_out}, 4'h2);
    apb(1'b1, OFS_CTRL, 32'h0000_000F);
    partner.level(1'b1, 3'h6);
    for (int i = 0; i < 4; i++) partner.pulse(i);
    repeat (8) @(posedge clk_in);
    chk({keys_locked_out, panel_sel_out, index_out}, 5'h04);
    chk(cnt[0] + cnt[1] + cnt[2] + cnt[3], 30);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    repeat (8) @(posedge clk_in);
    chk({keys_locked_out, panel_sel_out}, 4'hE);
    apb(1'b0, OFS_RESULT, 32'h0000_0000);
    chk(q, 32'h0000_007F);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_02DF);
    apb(1'b1, OFS_STATUS, 32'h0000_000F);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_02D0);
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_01D1);
    // A pin start while busy must be dropped
    partner.pulse(0);
    chk(cnt[0], 28);
    chk(32'(index_out), 32'h0000_0001);
    give_verdict();
  end
endmodule : test_control_io_judgment_tb_top
`default_nettype wire
